/* adcsq_pkg.sv */
// adcsq_pkg: shared constants and types of the converter sequencer block
// assumes a single 10 MHz oscillator clock and an APB register bus
package adcsq_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] ADCSQ_IDX_PORT_A_DATA = 8'h05;
    localparam logic [7:0] ADCSQ_IDX_PORT_E_DATA = 8'h09;
    localparam logic [7:0] ADCSQ_IDX_INTERRUPT_CORE_CONTROL = 8'h0b;
    localparam logic [7:0] ADCSQ_IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
    localparam logic [7:0] ADCSQ_IDX_PERIPHERAL_FLAGS_TWO = 8'h0d;
    localparam logic [7:0] ADCSQ_IDX_CONVERSION_RESULT_REG = 8'h1e;
    localparam logic [7:0] ADCSQ_IDX_CONVERTER_CONTROL_PRIMARY = 8'h1f;
    localparam logic [7:0] ADCSQ_IDX_PORT_A_DIRECTION = 8'h85;
    localparam logic [7:0] ADCSQ_IDX_PORT_E_DIRECTION = 8'h89;
    localparam logic [7:0] ADCSQ_IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
    localparam logic [7:0] ADCSQ_IDX_PERIPHERAL_ENABLES_TWO = 8'h8d;
    localparam logic [7:0] ADCSQ_IDX_CONVERTER_PORT_CONFIG = 8'h9f;
    localparam int ADCSQ_ADDR_W = 12;

    // field positions
    localparam int ADCSQ_CS_LSB = 6;
    localparam int ADCSQ_CHS_LSB = 3;
    localparam int ADCSQ_GO_BIT = 2;
    localparam int ADCSQ_ON_BIT = 0;
    localparam int ADCSQ_DONE_FLAG_BIT = 6;
    localparam int ADCSQ_IRQ_EN_BIT = 6;
    localparam int ADCSQ_GLB_BIT = 7;

    // reset values
    localparam logic [7:0] ADCSQ_CTRL_RST = 8'h00;
    localparam logic [2:0] ADCSQ_PCFG_RST = 3'h0;
    localparam logic [5:0] ADCSQ_DIRA_RST = 6'h3f;
    localparam logic [2:0] ADCSQ_DIRE_RST = 3'h7;
    localparam logic ADCSQ_FLAG_RST = 1'b0;

    // timing: oscillator periods per bit period, conversion length in half bit periods
    localparam int ADCSQ_CLK_NS = 100;
    localparam int ADCSQ_TOSC_NS = 100;
    localparam int ADCSQ_TOSC_PER_BIT_0 = 2;
    localparam int ADCSQ_TOSC_PER_BIT_1 = 8;
    localparam int ADCSQ_TOSC_PER_BIT_2 = 32;
    localparam int ADCSQ_CONV_HALF_BITS = 19;
    localparam int ADCSQ_FIRST_DECISION = 3;

    // capture/compare mode that raises the special event trigger
    localparam logic [3:0] ADCSQ_CCP_SPECIAL_EVENT = 4'hb;

    // analog pin masks of port a (bits 0,1,2,3,5)
    localparam logic [5:0] ADCSQ_MASK_ALL_ANALOG = 6'h2f;
    localparam logic [5:0] ADCSQ_MASK_TWO_DIGITAL = 6'h0b;
    localparam logic [5:0] ADCSQ_MASK_NONE = 6'h00;

    typedef enum logic {ADCSQ_IDLE, ADCSQ_RUN} adcsq_seq_state_t;

endpackage : adcsq_pkg

/* adcsq_conv_if.sv */
// adcsq_conv_if: link between the control logic and the approximation sequencer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface adcsq_conv_if;
    logic start;
    logic abort;
    logic half_tick;
    logic cmp_above;
    logic busy;
    logic done;
    logic hold_connected;
    logic [7:0] value;

    modport ctl (output start, abort, half_tick, cmp_above,
                 input busy, done, hold_connected, value);
    modport seq (input start, abort, half_tick, cmp_above,
                 output busy, done, hold_connected, value);
endinterface : adcsq_conv_if

/* adcsq_sar.sv */
// adcsq_sar: successive approximation sequencer, one bit per bit period
// assumes half_tick pulses only while busy, two per bit period
`timescale 1ns/1ps
module adcsq_sar
    import adcsq_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control side
    adcsq_conv_if.seq conv
);

    typedef struct packed {
        adcsq_seq_state_t state;
        logic [4:0] cnt;
        logic [7:0] value;
        logic done;
        logic hold;
    } adcsq_sar_state_t;

    adcsq_sar_state_t s_q, s_d;
    logic [4:0] k;
    logic [4:0] off;
    logic [2:0] pos;

    // next state of the sequencer
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        k = s_q.cnt + 5'd1;
        off = k - 5'(ADCSQ_FIRST_DECISION);
        pos = 3'd7 - off[3:1];
        if (conv.abort) begin
            s_d.state = ADCSQ_IDLE;
            s_d.hold = 1'b1;
        end else if (conv.start && s_q.state == ADCSQ_IDLE) begin
            s_d.state = ADCSQ_RUN;
            s_d.cnt = 5'd0;
            s_d.value = 8'h80;            // msb trial first [R19]
            s_d.hold = 1'b0;              // sampling ends at start [R10]
        end else if (s_q.state == ADCSQ_RUN && conv.half_tick) begin
            s_d.cnt = k;
            // decisions on odd half periods 3..17, one per bit period [R19]
            if (k[0] && k >= 5'(ADCSQ_FIRST_DECISION) && k < 5'(ADCSQ_CONV_HALF_BITS)) begin
                if (!conv.cmp_above) begin
                    s_d.value[pos] = 1'b0;
                end
                if (pos != 3'd0) begin
                    s_d.value[pos - 3'd1] = 1'b1;
                end
            end
            // nine and a half bit periods end the conversion [R6]
            if (k == 5'(ADCSQ_CONV_HALF_BITS)) begin
                s_d.state = ADCSQ_IDLE;
                s_d.done = 1'b1;
                s_d.hold = 1'b1;
            end
        end
    end

    // state register; reset aborts any conversion [R18]
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{state: ADCSQ_IDLE, cnt: 5'd0, value: 8'h00, done: 1'b0, hold: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign conv.busy = (s_q.state == ADCSQ_RUN);
    assign conv.done = s_q.done;
    assign conv.value = s_q.value;
    assign conv.hold_connected = s_q.hold;

endmodule : adcsq_sar

/* adcsq_top.sv */
// adcsq_top: converter control, port configuration and result registers on apb
// assumes all inputs synchronous to i_clk; analog comparator and rc clock outside
`timescale 1ns/1ps

// Contract
// R1 - port config field picks analog pins and reference: 000/010, 001/011, 100/101, 11x
// R2 - on completion load result, clear go flag, set done flag
// R3 - result register untouched by any reset
// R4 - software waits the acquisition time before starting
// R5 - software waits two bit periods before next acquisition
// R6 - a conversion lasts nine and a half bit periods
// R7 - clock select: 2, 8, 32 oscillator periods or internal rc
// R8 - software keeps the bit period at 1.6 us or longer
// R9 - above 1 MHz use the rc clock only for sleep conversions
// R10 - holding capacitor disconnects when conversion starts
// R11 - port data read returns zero for analog pins
// R12 - selected channel converts whatever its direction or digital setup
// R13 - software turns converter on before setting go
// R14 - special event trigger in mode 1011 starts conversion and clears timer
// R15 - with converter off trigger starts nothing but still clears timer
// R16 - done flag sticks until cleared; with both enables raises interrupt
// R17 - control layout: clock 7-6, channel 5-3, go 2, zero 1, on 0
// R18 - any reset restores register defaults and aborts conversion
// R19 - eight bits resolved msb first, one per bit period, from comparator
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int ADDR_W = ADCSQ_ADDR_W
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // analog side
    input wire logic i_cmp_above,
    input wire logic i_rc_half_tick,
    output logic [7:0] o_trial,
    output logic [2:0] o_channel,
    output logic o_hold_connected,
    output logic o_vref_external,
    output logic [5:0] o_analog_mask,
    output logic o_converter_on,
    // port pins as read back
    input wire logic [5:0] i_port_a_pins,
    input wire logic [2:0] i_port_e_pins,
    output logic [5:0] o_port_a_direction,
    output logic [2:0] o_port_e_direction,
    // capture/compare unit two and secondary timer
    input wire logic [3:0] i_ccp_mode,
    input wire logic i_special_event,
    output logic o_timer_clear,
    // interrupt request
    output logic o_irq
);

    typedef struct packed {
        logic [1:0] cs;
        logic [2:0] chs;
        logic go;
        logic on;
        logic [2:0] pcfg;
        logic [5:0] dira;
        logic [2:0] dire;
        logic done_flag;
        logic irq_en;
        logic glb;
        logic [4:0] div_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic timer_clr;
        logic [5:0] amask;
        logic vref_ext;
    } adcsq_ctl_state_t;

    adcsq_ctl_state_t s_q, s_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    adcsq_conv_if conv ();

    // half bit period in clock cycles for the divided sources
    function automatic logic [4:0] half_len(input logic [1:0] cs);
        logic [4:0] n;
        n = 5'd1;
        unique case (cs)
            2'b00: n = 5'(ADCSQ_TOSC_PER_BIT_0 * ADCSQ_TOSC_NS / ADCSQ_CLK_NS / 2);
            2'b01: n = 5'(ADCSQ_TOSC_PER_BIT_1 * ADCSQ_TOSC_NS / ADCSQ_CLK_NS / 2);
            2'b10: n = 5'(ADCSQ_TOSC_PER_BIT_2 * ADCSQ_TOSC_NS / ADCSQ_CLK_NS / 2);
            2'b11: n = 5'd1;
        endcase
        return n;
    endfunction : half_len

    // pins that read as analog for a port configuration code
    function automatic logic [5:0] analog_mask(input logic [2:0] pcfg);
        logic [5:0] m;
        m = ADCSQ_MASK_NONE;
        unique case (pcfg)
            3'b000, 3'b001, 3'b010, 3'b011: m = ADCSQ_MASK_ALL_ANALOG;
            3'b100, 3'b101: m = ADCSQ_MASK_TWO_DIGITAL;
            3'b110, 3'b111: m = ADCSQ_MASK_NONE;
        endcase
        return m;
    endfunction : analog_mask

    // word-aligned match of a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction : hit

    adcsq_sar u_sar (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .conv(conv.seq)
    );

    // bus phases: prepare the answer in the first access cycle, commit at pready
    logic access_first;
    logic access_commit;
    logic wr;
    logic mapped;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic sw_start;
    logic sw_abort;
    logic trig_fire;
    logic trig_start;
    logic new_on;
    logic new_go;

    assign access_first = i_psel && i_penable && !s_q.pready;
    assign access_commit = i_psel && i_penable && s_q.pready;
    assign wr = access_commit && i_pwrite;
    assign wdat = i_pwdata[7:0];

    // read mux and address decode
    always_comb begin
        rdat = 8'h00;
        mapped = 1'b1;
        if (hit(i_paddr, ADCSQ_IDX_PORT_A_DATA)) begin
            rdat = {2'b00, i_port_a_pins & ~s_q.amask};     // [R11]
        end else if (hit(i_paddr, ADCSQ_IDX_PORT_E_DATA)) begin
            rdat = {5'b00000, i_port_e_pins};
        end else if (hit(i_paddr, ADCSQ_IDX_INTERRUPT_CORE_CONTROL)) begin
            rdat[ADCSQ_GLB_BIT] = s_q.glb;
        end else if (hit(i_paddr, ADCSQ_IDX_PERIPHERAL_FLAGS_ONE)) begin
            rdat[ADCSQ_DONE_FLAG_BIT] = s_q.done_flag;
        end else if (hit(i_paddr, ADCSQ_IDX_PERIPHERAL_ENABLES_ONE)) begin
            rdat[ADCSQ_IRQ_EN_BIT] = s_q.irq_en;
        end else if (hit(i_paddr, ADCSQ_IDX_CONVERSION_RESULT_REG)) begin
            rdat = result_q;
        end else if (hit(i_paddr, ADCSQ_IDX_CONVERTER_CONTROL_PRIMARY)) begin
            rdat = {s_q.cs, s_q.chs, s_q.go, 1'b0, s_q.on};  // bit 1 reads zero [R17]
        end else if (hit(i_paddr, ADCSQ_IDX_PORT_A_DIRECTION)) begin
            rdat = {2'b00, s_q.dira};
        end else if (hit(i_paddr, ADCSQ_IDX_PORT_E_DIRECTION)) begin
            rdat = {5'b00000, s_q.dire};
        end else if (hit(i_paddr, ADCSQ_IDX_CONVERTER_PORT_CONFIG)) begin
            rdat = {5'b00000, s_q.pcfg};
        end else if (hit(i_paddr, ADCSQ_IDX_PERIPHERAL_FLAGS_TWO) ||
                     hit(i_paddr, ADCSQ_IDX_PERIPHERAL_ENABLES_TWO)) begin
            rdat = 8'h00;               // other units' bits live elsewhere
        end else begin
            mapped = 1'b0;
        end
    end

    // start and abort requests toward the sequencer
    always_comb begin
        new_on = wdat[ADCSQ_ON_BIT];
        new_go = wdat[ADCSQ_GO_BIT];
        // go only starts when the converter was already on [R13]
        sw_start = wr && hit(i_paddr, ADCSQ_IDX_CONVERTER_CONTROL_PRIMARY)
                   && new_go && new_on && s_q.on && !conv.busy;
        // clearing on or go mid-conversion aborts it
        sw_abort = wr && hit(i_paddr, ADCSQ_IDX_CONVERTER_CONTROL_PRIMARY)
                   && conv.busy && (!new_on || !new_go);
        trig_fire = i_special_event && (i_ccp_mode == ADCSQ_CCP_SPECIAL_EVENT);
        trig_start = trig_fire && s_q.on && !conv.busy && !sw_abort;  // [R14] [R15]
    end

    // bit-period divider, half periods, running only during a conversion
    always_comb begin
        conv.start = sw_start || trig_start;
        conv.abort = sw_abort;
        conv.cmp_above = i_cmp_above;       // comparator decision [R19]
        conv.half_tick = 1'b0;
        if (conv.busy) begin
            if (s_q.cs == 2'b11) begin
                conv.half_tick = i_rc_half_tick;                     // rc source [R7]
            end else begin
                conv.half_tick = (s_q.div_cnt == half_len(s_q.cs) - 5'd1);  // [R7]
            end
        end
    end

    // result register, no reset at all [R3]
    always_comb begin
        result_d = result_q;
        if (wr && hit(i_paddr, ADCSQ_IDX_CONVERSION_RESULT_REG)) begin
            result_d = wdat;
        end
        if (conv.done) begin
            result_d = conv.value;          // [R2]
        end
    end

    always_ff @(posedge i_clk) begin
        result_q <= result_d;               // [R3]
    end

    // next value of all control state
    always_comb begin
        s_d = s_q;
        // apb answer: ready one cycle into the access phase
        s_d.pready = access_first;
        s_d.pslverr = access_first && !mapped;
        if (access_first && !i_pwrite) begin
            s_d.prdata = {24'h000000, rdat};
        end
        // register writes take effect at the commit edge
        if (wr) begin
            if (hit(i_paddr, ADCSQ_IDX_CONVERTER_CONTROL_PRIMARY)) begin
                s_d.cs = wdat[ADCSQ_CS_LSB +: 2];        // [R17]
                s_d.chs = wdat[ADCSQ_CHS_LSB +: 3];      // [R17]
                s_d.on = new_on;
                s_d.go = sw_start || (conv.busy && !sw_abort);
            end
            if (hit(i_paddr, ADCSQ_IDX_CONVERTER_PORT_CONFIG)) begin
                s_d.pcfg = wdat[2:0];
            end
            if (hit(i_paddr, ADCSQ_IDX_PORT_A_DIRECTION)) begin
                s_d.dira = wdat[5:0];
            end
            if (hit(i_paddr, ADCSQ_IDX_PORT_E_DIRECTION)) begin
                s_d.dire = wdat[2:0];
            end
            if (hit(i_paddr, ADCSQ_IDX_PERIPHERAL_FLAGS_ONE)) begin
                s_d.done_flag = wdat[ADCSQ_DONE_FLAG_BIT];
            end
            if (hit(i_paddr, ADCSQ_IDX_PERIPHERAL_ENABLES_ONE)) begin
                s_d.irq_en = wdat[ADCSQ_IRQ_EN_BIT];
            end
            if (hit(i_paddr, ADCSQ_IDX_INTERRUPT_CORE_CONTROL)) begin
                s_d.glb = wdat[ADCSQ_GLB_BIT];
            end
        end
        // hardware trigger sets go [R14]
        if (trig_start) begin
            s_d.go = 1'b1;
        end
        // completion clears go and sets the flag; set beats a same-cycle clear [R2] [R16]
        if (conv.done) begin
            s_d.go = 1'b0;
            s_d.done_flag = 1'b1;
        end
        // divider restarts with each conversion so the first period is whole
        if (conv.start || !conv.busy || conv.half_tick) begin
            s_d.div_cnt = 5'd0;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 5'd1;
        end
        // timer clear follows the trigger whether or not the converter is on [R15]
        s_d.timer_clr = trig_fire;
        s_d.irq = s_d.done_flag && s_d.irq_en && s_d.glb;          // [R16]
        s_d.amask = analog_mask(s_d.pcfg);                          // [R1]
        s_d.vref_ext = (s_d.pcfg == 3'b001) || (s_d.pcfg == 3'b011)
                       || (s_d.pcfg == 3'b101);                     // [R1]
    end

    // control state register; any reset restores defaults [R18]
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{cs: ADCSQ_CTRL_RST[7:6], chs: ADCSQ_CTRL_RST[5:3],
                     go: ADCSQ_CTRL_RST[2], on: ADCSQ_CTRL_RST[0],
                     pcfg: ADCSQ_PCFG_RST, dira: ADCSQ_DIRA_RST, dire: ADCSQ_DIRE_RST,
                     done_flag: ADCSQ_FLAG_RST, irq_en: 1'b0, glb: 1'b0,
                     div_cnt: 5'd0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
                     irq: 1'b0, timer_clr: 1'b0, amask: ADCSQ_MASK_ALL_ANALOG,
                     vref_ext: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign o_prdata = s_q.prdata;
    assign o_pready = s_q.pready;
    assign o_pslverr = s_q.pslverr;
    assign o_trial = conv.value;                 // dac trial code [R19]
    assign o_channel = s_q.chs;                  // mux ignores pin direction [R12]
    assign o_hold_connected = conv.hold_connected;   // [R10]
    assign o_vref_external = s_q.vref_ext;
    assign o_analog_mask = s_q.amask;
    assign o_converter_on = s_q.on;
    assign o_port_a_direction = s_q.dira;
    assign o_port_e_direction = s_q.dire;
    assign o_timer_clear = s_q.timer_clr;
    assign o_irq = s_q.irq;

endmodule : adcsq_top

/* adcsq_top_properties.sv */
// adcsq_top_properties: port-level checks of the converter control block
// assumes binding to adcsq_top; one clock, async active-high reset
`timescale 1ns/1ps
module adcsq_top_properties
    import adcsq_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // converter
    input wire logic [7:0] o_trial,
    input wire logic o_hold_connected,
    input wire logic o_vref_external,
    input wire logic [5:0] o_analog_mask,
    input wire logic o_converter_on,
    // trigger
    input wire logic [3:0] i_ccp_mode,
    input wire logic i_special_event,
    input wire logic o_timer_clear
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // bus answers after exactly one wait state, as a single pulse
    chk_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held");
    chk_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    // trigger clears the timer whether or not the converter is on
    chk_timer_clear_cause: assert property (
        i_special_event && i_ccp_mode == 4'hb |=> o_timer_clear)
        else $error("timer clear missing");
    chk_timer_clear_only: assert property (
        o_timer_clear |-> $past(i_special_event) && $past(i_ccp_mode) == 4'hb)
        else $error("timer clear without trigger");
    // first cycle out of reset shows the converter on, hold, analog mask and trial defaults
    chk_reset_defaults: assert property ($fell(i_rst) |->
        !o_converter_on && o_hold_connected && o_analog_mask == 6'h2f && o_trial == 8'h00)
        else $error("reset defaults wrong");
    // disconnect of the holding cap goes with the first trial code
    chk_start_trial: assert property (
        $fell(o_hold_connected) |-> ##[0:1] o_trial == 8'h80)
        else $error("start trial wrong");
    chk_mask_legal: assert property (o_analog_mask inside {6'h2f, 6'h0b, 6'h00})
        else $error("analog mask illegal");
    chk_vref_mask: assert property (o_vref_external |-> o_analog_mask != 6'h00)
        else $error("reference with all digital");
endmodule : adcsq_top_properties

/* adcsq_analog_model.sv */
// adcsq_analog_model: ideal comparator and internal rc half-period ticks
// assumes the trial code is steady between clock edges
`timescale 1ns/1ps
module adcsq_analog_model #(
    parameter int RC_HALF = 20
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_level,
    input wire logic [7:0] i_trial,
    output logic o_cmp_above,
    output logic o_rc_half_tick
);
    int cnt;

    // ideal comparator: the level converts whatever the pin direction
    assign o_cmp_above = (i_level >= i_trial);

    // rc oscillator runs free, so tick phase is unrelated to any start
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
        end
    end
    assign o_rc_half_tick = (cnt == RC_HALF - 1);
endmodule : adcsq_analog_model

/* adcsq_top_test.sv */
// adcsq_top_test: self-checking bench of the converter control block
// assumes the analog model as comparator and rc source; apb master is here
`timescale 1ns/1ps
module adcsq_top_test;
    import adcsq_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} adcsq_row_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, cmp, rct, hold, vref, on, sev, tclr;
    logic irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] trial, level;
    logic [5:0] mask, dira;
    logic [2:0] chan, dire;
    logic [3:0] mode;
    int errors, cmp_count, n;
    logic [7:0] lv [4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
    int hh [4] = '{1, 4, 16, 20};
    // reset values, field masks, go refused while off, analog pins read zero
    adcsq_row_t rows [27] = '{
        '{0, 12'h07c, 0, 0, 0}, '{0, 12'h27c, 0, 0, 0}, '{0, 12'h214, 0, 32'h3f, 0},
        '{0, 12'h224, 0, 32'h07, 0}, '{0, 12'h230, 0, 0, 0}, '{0, 12'h030, 0, 0, 0},
        '{1, 12'h07c, 32'hfe, 0, 0}, '{0, 12'h07c, 0, 32'hf8, 0}, '{1, 12'h07c, 0, 0, 0},
        '{1, 12'h27c, 32'hff, 0, 0}, '{0, 12'h27c, 0, 32'h07, 0}, '{1, 12'h27c, 32'h04, 0, 0},
        '{0, 12'h014, 0, 32'h34, 0}, '{1, 12'h27c, 32'h06, 0, 0}, '{0, 12'h014, 0, 32'h3f, 0},
        '{1, 12'h27c, 32'h01, 0, 0}, '{0, 12'h014, 0, 32'h10, 0}, '{1, 12'h27c, 0, 0, 0},
        '{0, 12'h014, 0, 32'h10, 0}, '{1, 12'h034, 32'hff, 0, 0}, '{0, 12'h034, 0, 0, 0},
        '{1, 12'h214, 32'h15, 0, 0}, '{1, 12'h3f0, 32'h55, 0, 1}, '{0, 12'h3f0, 0, 0, 1},
        '{1, 12'h230, 32'h40, 0, 0}, '{1, 12'h02c, 32'h80, 0, 0}, '{0, 12'h02c, 0, 32'h80, 0}};

    adcsq_top DUT (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cmp_above(cmp), .i_rc_half_tick(rct),
        .o_trial(trial), .o_channel(chan), .o_hold_connected(hold), .o_vref_external(vref),
        .o_analog_mask(mask), .o_converter_on(on), .i_port_a_pins(6'h3f),
        .i_port_e_pins(3'h5), .o_port_a_direction(dira), .o_port_e_direction(dire),
        .i_ccp_mode(mode), .i_special_event(sev), .o_timer_clear(tclr), .o_irq(irq));
    adcsq_analog_model u_analog (.i_clk(clk), .i_rst(rst), .i_level(level), .i_trial(trial),
        .o_cmp_above(cmp), .o_rc_half_tick(rct));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask : rdc

    // counts cycles with the holding cap disconnected
    task automatic conv_wait();
        repeat (2) @(posedge clk);
        n = 1;
        while (hold !== 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask : conv_wait

    // mode set a cycle ahead so the pulse sees a steady mode
    task automatic trig(input logic [3:0] md);
        mode <= md;
        @(posedge clk);
        sev <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        @(posedge clk);
        chk("timer_clear", 32'(md == 4'hb), 32'(tclr));
    endtask : trig

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // roughly twenty-five times the expected run
    initial begin
        #4000000;
        errors++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 8'h00;
        mode = 4'h0;
        sev = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) begin
                chk("rdata", rows[i].q, q);
            end
            chk("slverr", 32'(rows[i].e), 32'(e));
        end
        chk("dir_a", 32'h15, 32'(dira));
        chk("dir_e", 32'h7, 32'(dire));
        bus(1'b1, 12'h27c, 32'h05);
        @(posedge clk);
        chk("vref", 32'h1, 32'(vref));
        $display("test register rows done");
        // short bit periods only exercise timing; the ideal model ignores them
        for (int c = 0; c < 4; c++) begin
            level <= lv[c];
            bus(1'b1, 12'h07c, 32'(c * 64 + (c + 1) * 8 + 1));
            repeat (20) @(posedge clk);
            bus(1'b1, 12'h07c, 32'(c * 64 + (c + 1) * 8 + 5));
            conv_wait();
            chk("conv_len", 32'h1, 32'(n >= 18 * hh[c] && n <= 19 * hh[c] + 2));
            rdc(12'h07c, 32'(c * 64 + (c + 1) * 8 + 1), "ctrl");
            rdc(12'h078, 32'(lv[c]), "result");
            rdc(12'h030, 32'h40, "done_flag");
            chk("irq", 32'h1, 32'(irq));
            chk("channel", 32'(c + 1), 32'(chan));
            bus(1'b1, 12'h030, 32'h0);
            repeat (3) @(posedge clk);
            chk("irq", 32'h0, 32'(irq));
            repeat (4 * hh[c]) @(posedge clk);
        end
        $display("test conversions done");
        level <= 8'h5a;
        bus(1'b1, 12'h07c, 32'h01);
        repeat (20) @(posedge clk);
        trig(4'hb);
        conv_wait();
        rdc(12'h078, 32'h5a, "result");
        rdc(12'h030, 32'h40, "done_flag");
        bus(1'b1, 12'h030, 32'h0);
        trig(4'h2);
        repeat (40) @(posedge clk);
        rdc(12'h030, 32'h0, "done_flag");
        bus(1'b1, 12'h07c, 32'h0);
        trig(4'hb);
        repeat (40) @(posedge clk);
        rdc(12'h07c, 32'h0, "ctrl");
        rdc(12'h030, 32'h0, "done_flag");
        $display("test trigger done");
        level <= 8'h11;
        bus(1'b1, 12'h07c, 32'h81);
        repeat (20) @(posedge clk);
        bus(1'b1, 12'h07c, 32'h85);
        repeat (40) @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        chk("on", 32'h0, 32'(on));
        chk("hold", 32'h1, 32'(hold));
        rst <= 1'b0;
        rdc(12'h078, 32'h5a, "result_kept");
        rdc(12'h07c, 32'h0, "ctrl");
        $display("test reset abort done");
        close_out();
    end
endmodule : adcsq_top_test

bind adcsq_top adcsq_top_properties u_props (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_trial(o_trial),
    .o_hold_connected(o_hold_connected), .o_vref_external(o_vref_external),
    .o_analog_mask(o_analog_mask), .o_converter_on(o_converter_on), .i_ccp_mode(i_ccp_mode),
    .i_special_event(i_special_event), .o_timer_clear(o_timer_clear));
